/* File: verilog/sofc_pkg.sv */
`default_nettype none
package sofc_pkg;
  // Register offsets on the serial control port
  localparam logic [6:0] ADDR_FRAME_CLK  = 7'h19;
  localparam logic [6:0] ADDR_DRIVE      = 7'h1A;
  localparam logic [6:0] ADDR_MAPPER     = 7'h1B;
  localparam logic [6:0] ADDR_LANE_DELAY = 7'h1E;
  localparam logic [7:0] REG_RESET       = 8'h00;
  // Field positions
  localparam int POS_SRC     = 7;
  localparam int POS_DIVIDE  = 4;
  localparam int POS_STRETCH = 0;
  localparam int POS_HALF    = 6;
  localparam int POS_MAP_EN  = 7;
  localparam int POS_WIDE    = 6;
  localparam int POS_RES_LO  = 3;
  localparam int POS_DDEL_LO = 2;
  localparam int POS_CDEL_LO = 0;
  // Width codes and widths
  localparam logic [2:0] RES_18 = 3'h0;
  localparam logic [2:0] RES_16 = 3'h1;
  localparam logic [2:0] RES_14 = 3'h2;
  localparam logic [4:0] WIDTH_20     = 5'h14;
  localparam logic [4:0] WIDTH_18     = 5'h12;
  localparam logic [4:0] WIDTH_16     = 5'h10;
  localparam logic [4:0] WIDTH_14     = 5'h0E;
  localparam logic [4:0] WIDTH_NATIVE = 5'h0E;
  localparam logic [19:0] FULL_MASK   = 20'hFFFFF;
  // Drive current in microamps: 3500 and 1750
  localparam logic [11:0] DRIVE_FULL_UA = 12'hDAC;
  localparam logic [11:0] DRIVE_HALF_UA = 12'h6D6;
  // Lane delay steps are 50 ps each, signed
  localparam int DELAY_STEP_PS = 50;
  localparam logic [2:0] STEP_NONE = 3'h0;
  localparam logic [2:0] STEP_ADV1 = 3'h7;
  localparam logic [2:0] STEP_DEL1 = 3'h1;
  localparam logic [2:0] STEP_DEL2 = 3'h2;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
  localparam logic [4:0] SPI_HDR_BITS   = 5'h08;

  typedef enum logic [2:0] {
    SOFC_BYPASS  = 3'b001,
    SOFC_REAL    = 3'b010,
    SOFC_COMPLEX = 3'b100
  } sofc_decim_e;

  typedef struct packed {
    logic       src;
    logic       divide;
    logic       stretch;
    logic       half;
    logic       map_en;
    logic       wide;
    logic [2:0] res;
    logic [1:0] ddel;
    logic [1:0] cdel;
  } sofc_regs_s;

  typedef struct packed {
    logic [19:0] data;
    logic [4:0]  width;
    logic        chan;
    logic        stretch;
    logic        divide;
  } sofc_word_s;
endpackage
`default_nettype wire

/* File: verilog/sofc_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module sofc_buf (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire sofc_pkg::sofc_word_s in_word,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  output sofc_pkg::sofc_word_s      out_word,
  output logic                      out_valid,
  input  wire logic                 out_ready
);
  typedef struct packed {
    sofc_pkg::sofc_word_s [1:0] mem;
    logic                       wp;
    logic                       rp;
    logic [1:0]                 cnt;
  } sofc_buf_s;

  sofc_buf_s st;
  sofc_buf_s next_st;
  logic      push;
  logic      pop;

  assign in_ready  = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_word  = st.mem[st.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_word;
      next_st.wp         = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  AST_BUF_COUNT: assert property (@(posedge mclk) disable iff (!reset_n)
    (push && !pop) |=> (st.cnt == $past(st.cnt) + 2'h1))
    else $error("Buffer count did not rise on push");
endmodule
`default_nettype wire

/* File: verilog/sofc_ser.sv */
`timescale 1ns/1ps
`default_nettype none
module sofc_ser (
  input  wire logic                 lclk,
  input  wire logic                 reset_n,
  input  wire logic                 req_tgl,
  input  wire sofc_pkg::sofc_word_s word,
  output logic                      ack_tgl,
  output logic                      lane_data,
  output logic                      frame_clock,
  output logic                      bit_clock_out
);
  typedef struct packed {
    logic [1:0]           rs;
    logic [2:0]           rq;
    logic                 last;
    logic                 busy;
    logic                 bclk;
    logic                 frame;
    logic                 ftog;
    logic [4:0]           cnt;
    logic [4:0]           pos;
    logic [19:0]          shreg;
    sofc_pkg::sofc_word_s w;
  } sofc_ser_s;

  sofc_ser_s st;
  sofc_ser_s next_st;
  logic      go;

  // A new word counts once the second and third stages agree
  assign go = st.rs[1] && (st.rq[1] == st.rq[2]) && (st.rq[2] != st.last);

  assign ack_tgl       = st.last;
  assign lane_data     = st.shreg[19];
  assign frame_clock   = st.frame;
  assign bit_clock_out = st.bclk;

  always_comb begin
    next_st    = st;
    next_st.rs = {st.rs[0], 1'b1};
    next_st.rq = {st.rq[1:0], req_tgl};
    if (st.busy && !st.bclk) begin
      next_st.bclk = 1'b1;
    end else if (st.busy) begin
      next_st.bclk  = 1'b0;
      next_st.shreg = {st.shreg[18:0], 1'b0};
      next_st.cnt   = st.cnt - 5'h01;
      next_st.pos   = st.pos + 5'h01;
      if (st.cnt == 5'h01) begin
        next_st.busy = 1'b0;
      end
    end
    // Back to back words: load on the last falling bit clock
    if (go && (!st.busy || (st.bclk && st.cnt == 5'h01))) begin
      next_st.busy  = 1'b1;
      next_st.bclk  = 1'b0;
      next_st.shreg = word.data;
      next_st.cnt   = word.width;
      next_st.pos   = 5'h00;
      next_st.w     = word;
      next_st.last  = st.rq[2];
      next_st.ftog  = ~st.ftog;
    end
    if (!next_st.busy) begin
      next_st.frame = 1'b0;
    end else if (next_st.w.stretch) begin
      next_st.frame = ~next_st.w.chan;
    end else if (next_st.w.divide) begin
      next_st.frame = next_st.ftog;
    end else begin
      next_st.frame = (next_st.pos < {1'b0, next_st.w.width[4:1]});
    end
  end

  always_ff @(posedge lclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  AST_STRETCH_FRAME: assert property (@(posedge lclk) disable iff (!reset_n)
    (st.busy && st.w.stretch) |-> (frame_clock == ~st.w.chan))
    else $error("Stretched frame clock does not follow channel");
endmodule
`default_nettype wire

/* File: verilog/sofc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Frame clock source bit 7: 0 core frame strobe, 1 decimation block strobe.
// - Stretch bit 0 makes the frame clock span channel A and B.
// - Drive bit 6 halves output current from 3.5 mA to 1.75 mA.
// - Mapper enable bit 7 changes width only in bypass; not for 20-bit.
// - Mapper bit 6 selects 20-bit output; clear disables it.
// - Width code bits 5..3: 000 18 (complex keeps 16), 001 16, 010 14, rest invalid.
// - Real decimation defaults 18 bits, complex 16; code works without enable.
// - Data delay bits 3..2: none, advance 50, delay 50, delay 100 ps.
// - Bit clock delay bits 1..0: none, advance 50, delay 50, delay 100 ps.
module sofc_top (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  spi_sen_n,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_sdi,
  output logic                       spi_sdo,
  output logic                       spi_sdo_oe,
  input  wire sofc_pkg::sofc_decim_e decim_mode,
  input  wire logic                  core_frame,
  input  wire logic                  decim_frame,
  output logic                       frame_strobe,
  input  wire logic [19:0]           smp_data,
  input  wire logic                  smp_chan,
  input  wire logic                  smp_valid,
  output logic                       smp_ready,
  input  wire logic                  lclk,
  output logic                       lane_data,
  output logic                       frame_clock,
  output logic                       bit_clock_out,
  output logic                       frame_clock_source_sel,
  output logic                       frame_clock_divide,
  output logic                       frame_clock_stretch,
  output logic                       half_drive_current,
  output logic [11:0]                drive_current_ua,
  output logic [4:0]                 out_width,
  output logic                       width_code_invalid,
  output logic [2:0]                 data_delay_steps,
  output logic [2:0]                 bit_clock_delay_steps
);
  typedef struct packed {
    logic [2:0]           sen_s;
    logic [2:0]           sclk_s;
    logic [2:0]           sdi_s;
    logic                 sen;
    logic                 sclk;
    logic [4:0]           bits;
    logic [15:0]          sh;
    logic [7:0]           rd;
    logic                 sdo_oe;
    logic                 wr_stb;
    logic [6:0]           wr_addr;
    logic [7:0]           wr_data;
    sofc_pkg::sofc_regs_s regs;
    sofc_pkg::sofc_word_s hold;
    logic                 req;
    logic                 pend;
    logic [2:0]           ack_s;
  } sofc_top_s;

  sofc_top_s            st;
  sofc_top_s            next_st;
  logic                 sclk_now;
  logic                 sen_now;
  logic                 rise;
  logic                 fall;
  logic [15:0]          new_sh;
  logic                 ack_seen;
  logic                 ack_tgl;
  sofc_pkg::sofc_word_s in_word;
  sofc_pkg::sofc_word_s buf_word;
  logic                 buf_valid;
  logic                 buf_ready;
  logic [4:0]           mode_default;

  function automatic logic [2:0] delay_steps(input logic [1:0] code);
    logic [2:0] s;
    s = sofc_pkg::STEP_NONE;
    unique case (code)
      2'h0: s = sofc_pkg::STEP_NONE;
      2'h1: s = sofc_pkg::STEP_ADV1;
      2'h2: s = sofc_pkg::STEP_DEL1;
      2'h3: s = sofc_pkg::STEP_DEL2;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] read_reg(input sofc_pkg::sofc_regs_s r,
                                          input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    // Reserved bits are not stored and read back zero
    if (a == sofc_pkg::ADDR_FRAME_CLK) begin
      v[sofc_pkg::POS_SRC]     = r.src;
      v[sofc_pkg::POS_DIVIDE]  = r.divide;
      v[sofc_pkg::POS_STRETCH] = r.stretch;
    end else if (a == sofc_pkg::ADDR_DRIVE) begin
      v[sofc_pkg::POS_HALF] = r.half;
    end else if (a == sofc_pkg::ADDR_MAPPER) begin
      v[sofc_pkg::POS_MAP_EN]                       = r.map_en;
      v[sofc_pkg::POS_WIDE]                         = r.wide;
      v[sofc_pkg::POS_RES_LO+2:sofc_pkg::POS_RES_LO] = r.res;
    end else if (a == sofc_pkg::ADDR_LANE_DELAY) begin
      v[sofc_pkg::POS_DDEL_LO+1:sofc_pkg::POS_DDEL_LO] = r.ddel;
      v[sofc_pkg::POS_CDEL_LO+1:sofc_pkg::POS_CDEL_LO] = r.cdel;
    end
    return v;
  endfunction

  // Stable levels: a pin change counts once stages two and three agree
  assign sclk_now = (st.sclk_s[1] == st.sclk_s[2]) ? st.sclk_s[2] : st.sclk;
  assign sen_now  = (st.sen_s[1] == st.sen_s[2]) ? st.sen_s[2] : st.sen;
  assign rise     = sclk_now & ~st.sclk & ~sen_now;
  assign fall     = ~sclk_now & st.sclk & ~sen_now;
  assign new_sh   = {st.sh[14:0], st.sdi_s[2]};
  assign ack_seen = st.pend && (st.ack_s[1] == st.ack_s[2]) && (st.ack_s[2] == st.req);

  always_comb begin
    next_st        = st;
    next_st.sen_s  = {st.sen_s[1:0], spi_sen_n};
    next_st.sclk_s = {st.sclk_s[1:0], spi_sclk};
    next_st.sdi_s  = {st.sdi_s[1:0], spi_sdi};
    next_st.ack_s  = {st.ack_s[1:0], ack_tgl};
    next_st.sclk   = sclk_now;
    next_st.sen    = sen_now;
    next_st.wr_stb = 1'b0;
    if (sen_now) begin
      next_st.bits   = 5'h00;
      next_st.sdo_oe = 1'b0;
    end else if (rise && st.bits != sofc_pkg::SPI_FRAME_BITS) begin
      next_st.sh   = new_sh;
      next_st.bits = st.bits + 5'h01;
      // Header done: a read drives the register out from the next bit
      if (st.bits == sofc_pkg::SPI_HDR_BITS - 5'h01 && new_sh[7]) begin
        next_st.rd     = read_reg(st.regs, new_sh[6:0]);
        next_st.sdo_oe = 1'b1;
      end
      if (st.bits == sofc_pkg::SPI_FRAME_BITS - 5'h01 && !new_sh[15]) begin
        next_st.wr_stb  = 1'b1;
        next_st.wr_addr = new_sh[14:8];
        next_st.wr_data = new_sh[7:0];
        if (new_sh[14:8] == sofc_pkg::ADDR_FRAME_CLK) begin
          next_st.regs.src     = new_sh[sofc_pkg::POS_SRC];
          next_st.regs.divide  = new_sh[sofc_pkg::POS_DIVIDE];
          next_st.regs.stretch = new_sh[sofc_pkg::POS_STRETCH];
        end
        if (new_sh[14:8] == sofc_pkg::ADDR_DRIVE) begin
          next_st.regs.half = new_sh[sofc_pkg::POS_HALF];
        end
        if (new_sh[14:8] == sofc_pkg::ADDR_MAPPER) begin
          next_st.regs.map_en = new_sh[sofc_pkg::POS_MAP_EN];
          next_st.regs.wide   = new_sh[sofc_pkg::POS_WIDE];
          next_st.regs.res    = new_sh[sofc_pkg::POS_RES_LO+2:sofc_pkg::POS_RES_LO];
        end
        if (new_sh[14:8] == sofc_pkg::ADDR_LANE_DELAY) begin
          next_st.regs.ddel = new_sh[sofc_pkg::POS_DDEL_LO+1:sofc_pkg::POS_DDEL_LO];
          next_st.regs.cdel = new_sh[sofc_pkg::POS_CDEL_LO+1:sofc_pkg::POS_CDEL_LO];
        end
      end
    end else if (fall && st.sdo_oe && st.bits > sofc_pkg::SPI_HDR_BITS) begin
      next_st.rd = {st.rd[6:0], 1'b0};
    end
    // Hold stays frozen until the link side echoes the toggle
    if (ack_seen) begin
      next_st.pend = 1'b0;
    end
    if (buf_valid && !st.pend) begin
      next_st.hold = buf_word;
      next_st.req  = ~st.req;
      next_st.pend = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign spi_sdo    = st.rd[7];
  assign spi_sdo_oe = st.sdo_oe;

  assign frame_strobe           = st.regs.src ? decim_frame : core_frame;
  assign frame_clock_source_sel = st.regs.src;
  assign frame_clock_divide     = st.regs.divide;
  assign frame_clock_stretch    = st.regs.stretch;
  assign half_drive_current     = st.regs.half;
  assign drive_current_ua       = st.regs.half ? sofc_pkg::DRIVE_HALF_UA
                                               : sofc_pkg::DRIVE_FULL_UA;
  assign data_delay_steps       = delay_steps(st.regs.ddel);
  assign bit_clock_delay_steps  = delay_steps(st.regs.cdel);

  // Output width from mode, mapper enable, wide bit and width code
  always_comb begin
    width_code_invalid = 1'b0;
    mode_default       = sofc_pkg::WIDTH_NATIVE;
    unique case (decim_mode)
      sofc_pkg::SOFC_BYPASS:  mode_default = sofc_pkg::WIDTH_NATIVE;
      sofc_pkg::SOFC_REAL:    mode_default = sofc_pkg::WIDTH_18;
      sofc_pkg::SOFC_COMPLEX: mode_default = sofc_pkg::WIDTH_16;
      default:                mode_default = sofc_pkg::WIDTH_NATIVE;
    endcase
    out_width = mode_default;
    // Enable matters only in bypass; decimation modes obey the code alone
    if (decim_mode != sofc_pkg::SOFC_BYPASS || st.regs.map_en) begin
      case (st.regs.res)
        sofc_pkg::RES_18: begin
          if (decim_mode != sofc_pkg::SOFC_COMPLEX) begin
            out_width = sofc_pkg::WIDTH_18;
          end
        end
        sofc_pkg::RES_16: out_width = sofc_pkg::WIDTH_16;
        sofc_pkg::RES_14: out_width = sofc_pkg::WIDTH_14;
        default:          width_code_invalid = 1'b1;
      endcase
    end
    if (st.regs.wide) begin
      out_width = sofc_pkg::WIDTH_20;
    end
  end

  // Keep the top out_width bits, zero below so the lane idles low
  assign in_word.data    = smp_data & ~(sofc_pkg::FULL_MASK >> out_width);
  assign in_word.width   = out_width;
  assign in_word.chan    = smp_chan;
  assign in_word.stretch = st.regs.stretch;
  assign in_word.divide  = st.regs.divide;

  sofc_buf sofc_buf_inst (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_word   (in_word),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_word  (buf_word),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  assign buf_ready = ~st.pend;

  sofc_ser sofc_ser_inst (
    .lclk          (lclk),
    .reset_n       (reset_n),
    .req_tgl       (st.req),
    .word          (st.hold),
    .ack_tgl       (ack_tgl),
    .lane_data     (lane_data),
    .frame_clock   (frame_clock),
    .bit_clock_out (bit_clock_out)
  );

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence seq_lane_write;
    st.wr_stb && (st.wr_addr == sofc_pkg::ADDR_LANE_DELAY);
  endsequence

  sequence seq_frame_write;
    st.wr_stb && (st.wr_addr == sofc_pkg::ADDR_FRAME_CLK);
  endsequence

  AST_FRAME_SRC: assert property (
    frame_strobe == (frame_clock_source_sel ? decim_frame : core_frame))
    else $error("Frame strobe taken from wrong source");

  AST_STRETCH_WRITE: assert property (
    seq_frame_write |-> (frame_clock_stretch == st.wr_data[0])
                     ##1 $stable(frame_clock_stretch) [*2])
    else $error("Stretch bit did not follow its write");

  AST_HALF_DRIVE: assert property (
    drive_current_ua == (half_drive_current ? 12'h6D6 : 12'hDAC))
    else $error("Drive current does not match half drive bit");

  AST_BYPASS_NATIVE: assert property (
    (decim_mode == sofc_pkg::SOFC_BYPASS && !st.regs.map_en && !st.regs.wide)
      |-> (out_width == 5'h0E))
    else $error("Bypass width changed without mapper enable");

  AST_WIDE_OUT: assert property (
    $rose(st.regs.wide) |-> (out_width == 5'h14) ##1 (out_width == 5'h14 || !st.regs.wide))
    else $error("Wide output not giving 20 bits");

  AST_RES_14: assert property (
    (st.regs.res == 3'h2 && !st.regs.wide && decim_mode != sofc_pkg::SOFC_BYPASS)
      |-> (out_width == 5'h0E) && !width_code_invalid)
    else $error("Width code 010 did not give 14 bits");

  AST_DECIM_DEFAULT: assert property (
    (st.regs.res == 3'h0 && !st.regs.wide && !st.regs.map_en)
      |-> (decim_mode != sofc_pkg::SOFC_REAL || out_width == 5'h12)
       && (decim_mode != sofc_pkg::SOFC_COMPLEX || out_width == 5'h10))
    else $error("Decimation default width wrong");

  // Advance is minus one step; the delay codes count up from the no-shift code
  AST_DATA_DELAY: assert property (
    seq_lane_write |-> (data_delay_steps == ((st.wr_data[3:2] == 2'h1) ? 3'h7
                        : {1'b0, st.wr_data[3:2]} - {2'h0, st.wr_data[3]})))
    else $error("Data delay steps do not match written code");

  AST_CLK_DELAY: assert property (
    seq_lane_write ##1 !st.wr_stb
      |-> (bit_clock_delay_steps == ((st.wr_data[1:0] == 2'h1) ? 3'h7
           : {1'b0, st.wr_data[1:0]} - {2'h0, st.wr_data[1]})))
    else $error("Bit clock delay steps do not match written code");

  sequence seq_drive_write;
    st.wr_stb && (st.wr_addr == sofc_pkg::ADDR_DRIVE);
  endsequence

  AST_HALF_WRITE: assert property (
    seq_drive_write |-> (half_drive_current == st.wr_data[sofc_pkg::POS_HALF]))
    else $error("Half drive bit did not follow its write");

  AST_SRC_WRITE: assert property (
    seq_frame_write |-> (frame_clock_source_sel == st.wr_data[sofc_pkg::POS_SRC]))
    else $error("Frame clock source bit did not follow its write");

  AST_WIDE_HOLD: assert property (
    st.regs.wide |-> (out_width == 5'h14))
    else $error("Wide bit set but width is not 20");

  AST_RES_16: assert property (
    (st.regs.res == 3'h1 && !st.regs.wide
      && (decim_mode != sofc_pkg::SOFC_BYPASS || st.regs.map_en)) |-> (out_width == 5'h10))
    else $error("Width code 001 did not give 16 bits");

  AST_CODE_INVALID: assert property (
    (st.regs.res > 3'h2 && (decim_mode != sofc_pkg::SOFC_BYPASS || st.regs.map_en))
      |-> width_code_invalid)
    else $error("Unused width code not flagged");

  AST_LOW_BITS_ZERO: assert property (
    (out_width == 5'h10) |-> (in_word.data[3:0] == 4'h0))
    else $error("Bits below the output width not cleared");
endmodule
`default_nettype wire

/* File: tb/sofc_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sofc_rx_model (
  input  wire logic       reset_n,
  input  wire logic       lane_data,
  input  wire logic       frame_clock,
  input  wire logic       bit_clock_out,
  input  wire logic [4:0] width,
  output logic [19:0]     rx_word,
  output logic [7:0]      rx_n
);
  logic [19:0] sh;
  logic [4:0]  cnt;
  logic        fc_prev;
  logic        start;
  logic [4:0]  nxt;
  assign start = frame_clock && !fc_prev;
  assign nxt   = start ? 5'h01 : cnt + 5'h01;
  // A word begins where the frame clock rises; bits are taken at the bit clock rise
  always_ff @(posedge bit_clock_out or negedge reset_n) begin
    if (!reset_n) begin
      sh <= 20'h00000;
      cnt <= 5'h00;
      fc_prev <= 1'h0;
      rx_word <= 20'h00000;
      rx_n <= 8'h00;
    end else begin
      fc_prev <= frame_clock;
      cnt <= nxt;
      sh <= start ? {19'h00000, lane_data} : {sh[18:0], lane_data};
      if (nxt == width) begin
        rx_word <= start ? {19'h00000, lane_data} : {sh[18:0], lane_data};
        rx_n <= rx_n + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/sofc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sofc_top_tb;
  logic                  mclk = 0, reset_n = 0, lclk = 0;
  logic                  spi_sen_n = 1, spi_sclk = 0, spi_sdi = 0, spi_sdo, spi_sdo_oe;
  sofc_pkg::sofc_decim_e decim_mode = sofc_pkg::SOFC_BYPASS;
  logic                  core_frame = 0, decim_frame = 0, frame_strobe;
  logic [19:0]           smp_data = 20'h00000, rx_word;
  logic                  smp_chan = 0, smp_valid = 0, smp_ready;
  logic                  lane_data, frame_clock, bit_clock_out, frame_clock_source_sel;
  logic                  frame_clock_divide, frame_clock_stretch, half_drive_current;
  logic [11:0]           drive_current_ua;
  logic [4:0]            out_width, rx_w = 5'h10;
  logic                  width_code_invalid;
  logic [2:0]            data_delay_steps, bit_clock_delay_steps;
  logic [7:0]            rx_n;
  int                    bad_count = 0, cmp_count = 0;
  sofc_top sofc_top_inst (.mclk, .reset_n, .spi_sen_n, .spi_sclk, .spi_sdi, .spi_sdo,
    .spi_sdo_oe, .decim_mode, .core_frame, .decim_frame, .frame_strobe, .smp_data,
    .smp_chan, .smp_valid, .smp_ready, .lclk, .lane_data, .frame_clock, .bit_clock_out,
    .frame_clock_source_sel, .frame_clock_divide, .frame_clock_stretch,
    .half_drive_current, .drive_current_ua, .out_width, .width_code_invalid,
    .data_delay_steps, .bit_clock_delay_steps);
  sofc_rx_model sofc_rx_model_inst (.reset_n, .lane_data, .frame_clock, .bit_clock_out,
    .width(rx_w), .rx_word, .rx_n);
  always #12.5 mclk = ~mclk;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end
  task chk(input string n, input logic [19:0] s, input logic [19:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Read data is taken just before each rise, once the device has shifted it out
  task spi(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rw, a, d};
    q = 8'h00;
    @(posedge mclk) spi_sen_n <= 0;
    repeat (4) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= f[i];
      repeat (5) @(posedge mclk);
      if (i < 8) q[i] = spi_sdo;
      if (i == 7) chk("sdo_oe", spi_sdo_oe, rw);
      spi_sclk <= 1;
      repeat (5) @(posedge mclk);
      spi_sclk <= 0;
    end
    repeat (5) @(posedge mclk);
    spi_sen_n <= 1;
    repeat (8) @(posedge mclk);
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'h0, a, d, q);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    spi(1'h1, a, 8'h00, q);
    chk("readback", q, e);
  endtask
  task t_reset;
    rd(sofc_pkg::ADDR_FRAME_CLK, 8'h00);
    rd(sofc_pkg::ADDR_DRIVE, 8'h00);
    rd(sofc_pkg::ADDR_MAPPER, 8'h00);
    rd(sofc_pkg::ADDR_LANE_DELAY, 8'h00);
    rd(7'h1C, 8'h00);
    chk("drive", drive_current_ua, 12'hDAC);
    chk("width", out_width, 5'h0E);
    chk("ddel", data_delay_steps, 3'h0);
    chk("cdel", bit_clock_delay_steps, 3'h0);
  endtask
  // Settings follow the host table: source only in complex, divide only in bypass
  task fc_case(input sofc_pkg::sofc_decim_e m, input logic [7:0] v);
    decim_mode <= m;
    wr(sofc_pkg::ADDR_FRAME_CLK, v);
    rd(sofc_pkg::ADDR_FRAME_CLK, v);
    chk("src", frame_clock_source_sel, v[7]);
    chk("div", frame_clock_divide, v[4]);
    chk("stretch", frame_clock_stretch, v[0]);
    core_frame <= 1;
    decim_frame <= 0;
    repeat (2) @(posedge mclk);
    chk("strobe", frame_strobe, !v[7]);
    core_frame <= 0;
    decim_frame <= 1;
    repeat (2) @(posedge mclk);
    chk("strobe", frame_strobe, v[7]);
  endtask
  task t_drive;
    wr(sofc_pkg::ADDR_DRIVE, 8'h40);
    rd(sofc_pkg::ADDR_DRIVE, 8'h40);
    chk("half", half_drive_current, 1'h1);
    chk("drive", drive_current_ua, 12'h6D6);
    wr(sofc_pkg::ADDR_DRIVE, 8'h00);
    chk("drive", drive_current_ua, 12'hDAC);
  endtask
  task map_case(input sofc_pkg::sofc_decim_e m, input logic [7:0] v, input logic [4:0] w,
                input logic inv);
    decim_mode <= m;
    wr(sofc_pkg::ADDR_MAPPER, v);
    rd(sofc_pkg::ADDR_MAPPER, v);
    chk("out_width", out_width, w);
    chk("code_invalid", width_code_invalid, inv);
  endtask
  task t_delay;
    logic [2:0] st [4];
    st = '{sofc_pkg::STEP_NONE, sofc_pkg::STEP_ADV1, sofc_pkg::STEP_DEL1, sofc_pkg::STEP_DEL2};
    for (int i = 0; i < 4; i++) begin
      wr(sofc_pkg::ADDR_LANE_DELAY, {4'h0, i[1:0], 2'(3 - i)});
      chk("ddel", data_delay_steps, st[i]);
      chk("cdel", bit_clock_delay_steps, st[3 - i]);
    end
  endtask
  // Six words back to back overrun the buffer; a stretched or divided frame clock
  // marks only every other word, so the receiver then sees the even ones
  task t_stream(input sofc_pkg::sofc_decim_e m, input logic [7:0] fc, input int step);
    logic [19:0] d [6];
    logic        st;
    int          t;
    logic [7:0]  b;
    d = '{20'hABCDE, 20'h12345, 20'hFEDCB, 20'h0F0F0, 20'h80001, 20'h7FFFE};
    st = 0;
    wr(sofc_pkg::ADDR_FRAME_CLK, fc);
    map_case(m, 8'h88, 5'h10, 1'h0);
    b = rx_n;
    fork
      begin
        for (int k = 0; k < 6; k++) begin
          smp_data <= d[k];
          smp_chan <= k[0];
          smp_valid <= 1;
          @(posedge mclk);
          while (smp_ready !== 1'h1) begin
            st = 1;
            @(posedge mclk);
          end
        end
        smp_valid <= 0;
      end
      for (int n = 0; n < 6; n += step) begin
        t = 0;
        while (rx_n == b && t < 2000) begin
          @(posedge mclk);
          t++;
        end
        b = rx_n;
        chk("lane_word", rx_word, d[n] >> 4);
        chk("lane_time", t < 2000, 1'h1);
      end
    join
    chk("stall", st, 1'h1);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    repeat (6) @(posedge mclk);
    t_reset;
    fc_case(sofc_pkg::SOFC_COMPLEX, 8'h80);
    fc_case(sofc_pkg::SOFC_COMPLEX, 8'h01);
    fc_case(sofc_pkg::SOFC_BYPASS, 8'h10);
    fc_case(sofc_pkg::SOFC_BYPASS, 8'h00);
    t_drive;
    map_case(sofc_pkg::SOFC_BYPASS, 8'h80, 5'h12, 1'h0);
    map_case(sofc_pkg::SOFC_BYPASS, 8'h90, 5'h0E, 1'h0);
    map_case(sofc_pkg::SOFC_BYPASS, 8'h08, 5'h0E, 1'h0);
    map_case(sofc_pkg::SOFC_REAL, 8'h00, 5'h12, 1'h0);
    map_case(sofc_pkg::SOFC_REAL, 8'h08, 5'h10, 1'h0);
    map_case(sofc_pkg::SOFC_REAL, 8'h10, 5'h0E, 1'h0);
    map_case(sofc_pkg::SOFC_COMPLEX, 8'h00, 5'h10, 1'h0);
    map_case(sofc_pkg::SOFC_COMPLEX, 8'h10, 5'h0E, 1'h0);
    map_case(sofc_pkg::SOFC_COMPLEX, 8'h18, 5'h10, 1'h1);
    map_case(sofc_pkg::SOFC_BYPASS, 8'h40, 5'h14, 1'h0);
    map_case(sofc_pkg::SOFC_REAL, 8'h50, 5'h14, 1'h0);
    t_delay;
    t_stream(sofc_pkg::SOFC_BYPASS, 8'h00, 1);
    t_stream(sofc_pkg::SOFC_COMPLEX, 8'h01, 2);
    t_stream(sofc_pkg::SOFC_BYPASS, 8'h10, 2);
    end_sim;
  end
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
endmodule
`default_nettype wire
